// >>> core/lhp_host_port.sv
// Host pin interface of the display controller with an APB register window
// Functional notes
// - Strap low selects serial link; strap high selects 4-bit or 8-bit bus.
// - Instruction-set strap high picks first encoding, low picks alternative.
// - Bus mode: select high addresses data register, low command register.
// - Serial mode: select pin is active-low chip select; link ignored while high.
// - Bus mode: direction high requests read, low requests write.
// - Serial mode: direction pin carries serial input bits from host.
// - Strobe pin is bus enable in bus mode, serial clock in serial mode.
// - Serial mode: lane 0 is serial output, driven only during reads.
// - 8-bit mode: all eight lanes bidirectional, low lanes low bits.
// - 4-bit mode: upper lanes carry both halves; lower lanes stay open.
// - Select/direction decode: command write, status read, data write, data read.
// - Command refused while busy flag is high; host polls flag first.
// - Bus-width bit in a command chooses 4-bit or 8-bit transfers.
// - Host data read requests next RAM byte; written byte moves to RAM.
//
// Local design decisions: the APB register port and the register addresses.
module lhp_host_port
    import lhp_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire logic        i_interface_select_strap,
    input  wire logic        i_instruction_set_strap,
    input  wire logic        i_register_or_chip_select,
    input  wire logic        i_direction_or_serial_input,
    input  wire logic        i_strobe_or_serial_clock,
    input  wire logic [7:0]  i_db,
    output logic      [7:0]  o_db,
    output logic      [7:0]  o_db_oe_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    lhp_pins_t      pin_s1_ff, pin_s2_ff, pin_d_ff;
    logic [1:0]     strap_s1_ff, strap_s2_ff;
    logic           wide_ff, phase_ff;
    logic [3:0]     hi_nib_ff;
    lhp_ser_state_t ser_st_ff;
    logic [3:0]     ser_cnt_ff;
    logic           ser_rw_ff, ser_rs_ff;
    logic [7:0]     ser_sh_ff;
    logic [7:0]     cmd_ff, wdata_ff, rhold_ff;
    logic [6:0]     addr_cnt_ff;
    logic           busy_ff, cmd_v_ff, dat_v_ff, fetch_ff;
    logic [7:0]     db_ff, oe_n_ff;
    logic [31:0]    prdata_ff;
    logic           pready_ff, pslverr_ff;

    function automatic logic [7:0] lane_word(input logic [7:0] b, input logic wide, input logic ph);
        lane_word = wide ? b : {(ph ? b[3:0] : b[7:4]), 4'h0};
    endfunction : lane_word

    function automatic logic [7:0] read_byte(input logic sel, input logic [7:0] hold,
                                             input logic bsy, input logic [6:0] cnt);
        read_byte = sel ? hold : {bsy, cnt};
    endfunction : read_byte

    // Two-flop synchronisers, then one extra stage for edge finding
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_s1_ff   <= LHP_PINS_RST;
            pin_s2_ff   <= LHP_PINS_RST;
            pin_d_ff    <= LHP_PINS_RST;
            strap_s1_ff <= 2'h3;
            strap_s2_ff <= 2'h3;
        end else if (i_ce) begin
            pin_s1_ff   <= '{sel: i_register_or_chip_select, dir: i_direction_or_serial_input,
                             strobe: i_strobe_or_serial_clock, db: i_db};
            pin_s2_ff   <= pin_s1_ff;
            pin_d_ff    <= pin_s2_ff;
            strap_s1_ff <= {i_interface_select_strap, i_instruction_set_strap};
            strap_s2_ff <= strap_s1_ff;
        end
    end

    logic bus_mode, iset_first, stb_rise, stb_fall;
    assign bus_mode   = strap_s2_ff[1];
    assign iset_first = strap_s2_ff[0];
    assign stb_rise   = pin_s2_ff.strobe & ~pin_d_ff.strobe;
    assign stb_fall   = ~pin_s2_ff.strobe & pin_d_ff.strobe;

    // Transfer events from either path
    logic       wr_evt, wr_sel, rd_done;
    logic [7:0] wr_byte;
    logic       par_last, ser_active;
    assign par_last   = wide_ff | phase_ff;
    assign ser_active = ~bus_mode & ~pin_s2_ff.sel;

    always_comb begin
        wr_evt  = 1'b0;
        wr_sel  = 1'b0;
        rd_done = 1'b0;
        wr_byte = LHP_BYTE_RST;
        if (bus_mode && stb_fall && par_last) begin
            wr_sel  = pin_s2_ff.sel;
            wr_evt  = ~pin_s2_ff.dir;
            rd_done = pin_s2_ff.dir & pin_s2_ff.sel;
            wr_byte = wide_ff ? pin_s2_ff.db : {hi_nib_ff, pin_s2_ff.db[7:4]};
        end else if (ser_active && stb_rise && ser_st_ff == SP_WDAT && ser_cnt_ff == LHP_SER_BYTE_BITS - 4'h1) begin
            wr_evt  = 1'b1;
            wr_sel  = ser_rs_ff;
            wr_byte = {ser_sh_ff[6:0], pin_s2_ff.dir};
        end else if (ser_active && stb_fall && ser_st_ff == SP_RDAT && ser_cnt_ff == LHP_SER_BYTE_BITS) begin
            rd_done = ser_rs_ff;
        end
    end

    logic cmd_take;
    assign cmd_take = wr_evt & ~wr_sel & ~busy_ff;

    // Bus-width bit and nibble phase
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wide_ff   <= LHP_WIDE_RST;
            phase_ff  <= 1'b0;
            hi_nib_ff <= 4'h0;
        end else if (i_ce) begin
            if (cmd_take && wr_byte[7:5] == LHP_FSET_PATTERN)
                wide_ff <= wr_byte[LHP_FSET_WIDTH_BIT];
            if (!bus_mode || wide_ff) begin
                phase_ff <= 1'b0;
            end else if (stb_fall) begin
                phase_ff <= ~phase_ff;
                if (!phase_ff)
                    hi_nib_ff <= pin_s2_ff.db[7:4];
            end
        end
    end

    // Serial framing: read/write bit, select bit, then eight data bits
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ser_st_ff  <= SP_IDLE;
            ser_cnt_ff <= 4'h0;
            ser_rw_ff  <= 1'b0;
            ser_rs_ff  <= 1'b0;
            ser_sh_ff  <= LHP_BYTE_RST;
        end else if (i_ce) begin
            if (!ser_active) begin
                ser_st_ff  <= SP_IDLE;
                ser_cnt_ff <= 4'h0;
            end else begin
                case (ser_st_ff)
                    SP_IDLE: begin
                        ser_st_ff  <= SP_HDR;
                        ser_cnt_ff <= 4'h0;
                    end
                    SP_HDR: begin
                        if (stb_rise) begin
                            ser_cnt_ff <= ser_cnt_ff + 4'h1;
                            if (ser_cnt_ff == 4'h0)
                                ser_rw_ff <= pin_s2_ff.dir;
                            if (ser_cnt_ff == LHP_SER_HDR_BITS - 4'h1) begin
                                ser_rs_ff  <= pin_s2_ff.dir;
                                ser_cnt_ff <= 4'h0;
                                ser_st_ff  <= ser_rw_ff ? SP_RDAT : SP_WDAT;
                                ser_sh_ff  <= read_byte(pin_s2_ff.dir, rhold_ff, busy_ff, addr_cnt_ff);
                            end
                        end
                    end
                    SP_WDAT: begin
                        if (stb_rise) begin
                            ser_sh_ff  <= {ser_sh_ff[6:0], pin_s2_ff.dir};
                            ser_cnt_ff <= (ser_cnt_ff == LHP_SER_BYTE_BITS - 4'h1) ? 4'h0 : ser_cnt_ff + 4'h1;
                        end
                    end
                    SP_RDAT: begin
                        if (stb_fall && ser_cnt_ff != LHP_SER_BYTE_BITS) begin
                            ser_sh_ff  <= {ser_sh_ff[6:0], 1'b0};
                            ser_cnt_ff <= ser_cnt_ff + 4'h1;
                        end else if (stb_fall) begin
                            ser_st_ff <= SP_HDR;
                            ser_cnt_ff <= 4'h0;
                        end
                    end
                    default: ser_st_ff <= SP_IDLE;
                endcase
            end
        end
    end

    // Pin drive: bus read data or serial output bit
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            db_ff   <= 8'h00;
            oe_n_ff <= 8'hFF;
        end else if (i_ce) begin
            if (bus_mode) begin
                if (stb_rise && pin_s2_ff.dir) begin
                    db_ff   <= lane_word(read_byte(pin_s2_ff.sel, rhold_ff, busy_ff, addr_cnt_ff),
                                         wide_ff, phase_ff);
                    oe_n_ff <= wide_ff ? 8'h00 : 8'h0F;
                end else if (stb_fall || !pin_s2_ff.dir) begin
                    oe_n_ff <= 8'hFF;
                end
            end else if (ser_active && ser_st_ff == SP_RDAT) begin
                if (stb_fall && ser_cnt_ff != LHP_SER_BYTE_BITS) begin
                    db_ff   <= {7'h00, ser_sh_ff[7]};
                    oe_n_ff <= 8'hFE;
                end else if (stb_fall) begin
                    oe_n_ff <= 8'hFF;
                end
            end else begin
                oe_n_ff <= 8'hFF;
            end
        end
    end

    // APB slave: one wait state, then pready
    logic apb_acc, apb_wr, apb_rd, addr_ok;
    assign apb_acc = psel & penable & pready_ff;
    assign apb_wr  = apb_acc & pwrite;
    assign apb_rd  = apb_acc & ~pwrite;
    assign addr_ok = paddr == LHP_OFF_STATUS || paddr == LHP_OFF_CMD || paddr == LHP_OFF_WDATA
                  || paddr == LHP_OFF_RDATA || paddr == LHP_OFF_ADDR || paddr == LHP_OFF_CTRL;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (i_ce) begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~addr_ok;
            if (psel && penable && !pready_ff && !pwrite) begin
                case (paddr)
                    LHP_OFF_STATUS: prdata_ff <= {25'h0, fetch_ff, busy_ff, dat_v_ff, cmd_v_ff,
                                                  wide_ff, iset_first, bus_mode};
                    LHP_OFF_CMD:    prdata_ff <= {24'h0, cmd_ff};
                    LHP_OFF_WDATA:  prdata_ff <= {24'h0, wdata_ff};
                    LHP_OFF_RDATA:  prdata_ff <= {24'h0, rhold_ff};
                    LHP_OFF_ADDR:   prdata_ff <= {25'h0, addr_cnt_ff};
                    default:        prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command, data and busy state; hardware set wins over software clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd_ff   <= LHP_BYTE_RST;
            wdata_ff <= LHP_BYTE_RST;
            rhold_ff    <= LHP_BYTE_RST;
            addr_cnt_ff <= LHP_ADDR_CNT_RST;
            busy_ff  <= 1'b0;
            cmd_v_ff <= 1'b0;
            dat_v_ff <= 1'b0;
            fetch_ff <= 1'b0;
        end else if (i_ce) begin
            if (apb_wr && paddr == LHP_OFF_RDATA)
                rhold_ff <= pwdata[7:0];
            if (apb_wr && paddr == LHP_OFF_ADDR)
                addr_cnt_ff <= pwdata[6:0];
            if (cmd_take) begin
                cmd_ff   <= wr_byte;
                cmd_v_ff <= 1'b1;
                busy_ff  <= 1'b1;
            end else begin
                if (apb_rd && paddr == LHP_OFF_CMD)
                    cmd_v_ff <= 1'b0;
                if (apb_wr && paddr == LHP_OFF_CTRL && pwdata[LHP_CTRL_CLRBUSY])
                    busy_ff <= 1'b0;
            end
            if (wr_evt && wr_sel) begin
                wdata_ff <= wr_byte;
                dat_v_ff <= 1'b1;
            end else if (apb_rd && paddr == LHP_OFF_WDATA) begin
                dat_v_ff <= 1'b0;
            end
            if (rd_done)
                fetch_ff <= 1'b1;
            else if (apb_wr && paddr == LHP_OFF_RDATA)
                fetch_ff <= 1'b0;
        end
    end

    assign o_db      = db_ff;
    assign o_db_oe_n = oe_n_ff;
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_serial_out_idle: assert property (i_ce && !bus_mode && ser_st_ff != SP_RDAT ##1 i_ce |-> o_db_oe_n[0])
        else $error("serial output driven outside a read");
    a_low_lanes_open: assert property (!bus_mode || !wide_ff |-> ##1 o_db_oe_n[3:1] == 3'h7)
        else $error("low lanes driven outside 8-bit mode");
    a_cmd_refused_busy: assert property (i_ce && wr_evt && !wr_sel && busy_ff |=> $stable(cmd_ff))
        else $error("command taken while busy");
    a_cmd_sets_busy: assert property (i_ce && cmd_take |=> busy_ff && cmd_ff == $past(wr_byte))
        else $error("accepted command did not set busy");
    a_width_bit: assert property (i_ce && cmd_take && wr_byte[7:5] == LHP_FSET_PATTERN
                                  |=> wide_ff == $past(wr_byte[LHP_FSET_WIDTH_BIT]))
        else $error("bus width bit not applied");
    a_bus_read_drive: assert property (i_ce && bus_mode && stb_rise && pin_s2_ff.dir
                                       |=> o_db_oe_n[7:4] == 4'h0)
        else $error("bus read did not drive upper lanes");
    a_status_read: assert property (i_ce && bus_mode && wide_ff && stb_rise && pin_s2_ff.dir && !pin_s2_ff.sel
                                    |=> o_db == {$past(busy_ff), $past(addr_cnt_ff)})
        else $error("status read returned wrong value");
    a_cs_ignores: assert property (i_ce && !bus_mode && pin_s2_ff.sel |=> ser_st_ff == SP_IDLE)
        else $error("serial link active while deselected");
    a_fetch_request: assert property (i_ce && rd_done |=> fetch_ff)
        else $error("data read did not request next byte");
    a_apb_ready: assert property (psel && penable && !pready && i_ce |=> pready ##1 !pready)
        else $error("pready not a single-cycle answer");
endmodule : lhp_host_port

// >>> core/lhp_pkg.sv
// Shared constants, types and register map of the display host port
package lhp_pkg;
    localparam logic [7:0] LHP_OFF_STATUS = 8'h00;
    localparam logic [7:0] LHP_OFF_CMD    = 8'h04;
    localparam logic [7:0] LHP_OFF_WDATA  = 8'h08;
    localparam logic [7:0] LHP_OFF_RDATA  = 8'h0C;
    localparam logic [7:0] LHP_OFF_ADDR   = 8'h10;
    localparam logic [7:0] LHP_OFF_CTRL   = 8'h14;

    localparam int LHP_ST_MODE_BIT  = 0;
    localparam int LHP_ST_ISET_BIT  = 1;
    localparam int LHP_ST_WIDE_BIT  = 2;
    localparam int LHP_ST_CMDV_BIT  = 3;
    localparam int LHP_ST_DATV_BIT  = 4;
    localparam int LHP_ST_BUSY_BIT  = 5;
    localparam int LHP_ST_FETCH_BIT = 6;
    localparam int LHP_CTRL_CLRBUSY = 0;

    localparam logic [2:0] LHP_FSET_PATTERN = 3'h1;
    localparam int         LHP_FSET_WIDTH_BIT = 4;
    localparam logic       LHP_WIDE_RST       = 1'h1;
    localparam logic [7:0] LHP_BYTE_RST       = 8'h00;
    localparam logic [6:0] LHP_ADDR_CNT_RST   = 7'h00;
    localparam logic [3:0] LHP_SER_HDR_BITS = 4'h2;
    localparam logic [3:0] LHP_SER_BYTE_BITS = 4'h8;

    typedef struct packed {
        logic       sel;
        logic       dir;
        logic       strobe;
        logic [7:0] db;
    } lhp_pins_t;

    localparam lhp_pins_t LHP_PINS_RST = '{sel: 1'b1, dir: 1'b0, strobe: 1'b0, db: 8'h00};

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_HDR  = 2'b01,
        SP_WDAT = 2'b10,
        SP_RDAT = 2'b11
    } lhp_ser_state_t;
endpackage : lhp_pkg

// >>> sim/lhp_host_model.sv
// Host processor model driving the shared pins of the display port
module lhp_host_model
    import lhp_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_dev_db,
    input  wire logic [7:0] i_dev_oe_n,
    output logic            o_sel,
    output logic            o_dir,
    output logic            o_strobe,
    output logic      [7:0] o_db,
    output logic      [7:0] o_db_en
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sel    = 1'h1;
        o_dir    = 1'h0;
        o_strobe = 1'h0;
        o_db     = 8'h00;
        o_db_en  = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask : hold

    // One strobe of 800 ns; lanes sampled at end of high phase
    task automatic strobe_one(input logic sel, input logic dir, input logic [7:0] wd, input logic [7:0] en,
                              output logic [7:0] rd, output logic [7:0] oe);
        o_sel    <= sel;
        o_dir    <= dir;
        o_db     <= wd;
        o_db_en  <= dir ? 8'h00 : en;
        hold(1);
        o_strobe <= 1'h1;
        hold(4);
        rd = i_dev_db;
        oe = i_dev_oe_n;
        o_strobe <= 1'h0;
        hold(2);
        o_db_en  <= 8'h00;
        hold(1);
    endtask : strobe_one

    task automatic bus_xfer(input logic sel, input logic dir, input logic wide, input logic [7:0] wd,
                            output logic [7:0] rd, output logic lo_open);
        logic [7:0] r1;
        logic [7:0] r2;
        logic [7:0] e1;
        logic [7:0] e2;
        if (wide) begin
            strobe_one(sel, dir, wd, 8'hFF, r1, e1);
            rd = r1;
            lo_open = 1'h1;
        end else begin
            strobe_one(sel, dir, {wd[7:4], 4'h0}, 8'hF0, r1, e1);
            strobe_one(sel, dir, {wd[3:0], 4'h0}, 8'hF0, r2, e2);
            rd = {r1[7:4], r2[7:4]};
            lo_open = &{e1[3:0], e2[3:0]};
        end
    endtask : bus_xfer

    // Serial frame: direction bit, select bit, then 8 bits MSB first
    task automatic ser_frame(input logic cs_n, input logic rw, input logic rs, input logic [7:0] wd,
                             output logic [7:0] rd);
        logic [9:0] bits;
        bits = {rw, rs, wd};
        o_sel <= cs_n;
        hold(2);
        for (int i = 9; i >= 0; i--) begin
            o_strobe <= 1'h0;
            o_dir    <= bits[i];
            hold(4);
            o_strobe <= 1'h1;
            hold(4);
            rd[i % 8] = i_dev_oe_n[0] ? ~i_dev_db[0] : i_dev_db[0];
        end
        o_sel <= 1'h1;
        hold(2);
    endtask : ser_frame
endmodule : lhp_host_model

// >>> sim/lhp_host_port_tb_top.sv
// Self-checking bench of the display host port
module lhp_host_port_tb_top
    import lhp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 1'h0;
    logic        i_nrst = 1'h0;
    logic        strap_bus = 1'h1;
    logic        strap_iset = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  dev_db;
    logic [7:0]  dev_oe_n;
    logic        h_sel;
    logic        h_dir;
    logic        h_stb;
    logic [7:0]  h_db;
    logic [7:0]  h_en;
    logic [7:0]  lane;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    always #50 i_clk = ~i_clk;
    // Undriven lanes float to the inverse of the last device value
    assign lane = (h_en & h_db) | (~h_en & ~dev_oe_n & dev_db) | (~h_en & dev_oe_n & ~dev_db);

    lhp_host_port lhp_host_port_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'h1),
        .i_interface_select_strap(strap_bus), .i_instruction_set_strap(strap_iset),
        .i_register_or_chip_select(h_sel), .i_direction_or_serial_input(h_dir),
        .i_strobe_or_serial_clock(h_stb), .i_db(lane), .o_db(dev_db), .o_db_oe_n(dev_oe_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    lhp_host_model lhp_host_model_i (.i_clk(i_clk), .i_dev_db(dev_db), .i_dev_oe_n(dev_oe_n),
        .o_sel(h_sel), .o_dir(h_dir), .o_strobe(h_stb), .o_db(h_db), .o_db_en(h_en));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge i_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'h1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    logic [31:0] r;
    logic        e;
    logic [7:0]  b;
    logic        lo;

    task automatic t_reset();
        apb(1'h0, LHP_OFF_STATUS, 32'h0, r, e);
        check("status", 32'h07, r);
        check("oe_n", 32'hFF, {24'h0, dev_oe_n});
        $display("test reset done");
    endtask : t_reset

    task automatic t_bus8();
        lhp_host_model_i.bus_xfer(1'h1, 1'h0, 1'h1, 8'hA5, b, lo);
        apb(1'h0, LHP_OFF_WDATA, 32'h0, r, e);
        check("wdata", 32'hA5, r);
        lhp_host_model_i.bus_xfer(1'h0, 1'h0, 1'h1, 8'h38, b, lo);
        lhp_host_model_i.bus_xfer(1'h0, 1'h0, 1'h1, 8'h01, b, lo);
        apb(1'h0, LHP_OFF_CMD, 32'h0, r, e);
        check("cmd busy", 32'h38, r);
        apb(1'h1, LHP_OFF_CTRL, 32'h1, r, e);
        lhp_host_model_i.bus_xfer(1'h0, 1'h0, 1'h1, 8'h01, b, lo);
        apb(1'h0, LHP_OFF_CMD, 32'h0, r, e);
        check("cmd", 32'h01, r);
        apb(1'h1, LHP_OFF_ADDR, 32'h15, r, e);
        lhp_host_model_i.bus_xfer(1'h0, 1'h1, 1'h1, 8'h00, b, lo);
        check("pin status", 32'h95, {24'h0, b});
        apb(1'h1, LHP_OFF_RDATA, 32'h3C, r, e);
        lhp_host_model_i.bus_xfer(1'h1, 1'h1, 1'h1, 8'h00, b, lo);
        check("pin data", 32'h3C, {24'h0, b});
        apb(1'h0, LHP_OFF_STATUS, 32'h0, r, e);
        check("fetch", 32'h40, r & 32'h40);
        apb(1'h0, 8'h18, 32'h0, r, e);
        check("unmapped", 32'h1, {r[30:0], e});
        $display("test bus8 done");
    endtask : t_bus8

    task automatic t_bus4();
        apb(1'h1, LHP_OFF_CTRL, 32'h1, r, e);
        lhp_host_model_i.bus_xfer(1'h0, 1'h0, 1'h1, 8'h20, b, lo);
        apb(1'h0, LHP_OFF_STATUS, 32'h0, r, e);
        check("wide", 32'h0, r & 32'h4);
        lhp_host_model_i.bus_xfer(1'h1, 1'h0, 1'h0, 8'h6B, b, lo);
        apb(1'h0, LHP_OFF_WDATA, 32'h0, r, e);
        check("wdata4", 32'h6B, r);
        lhp_host_model_i.bus_xfer(1'h0, 1'h1, 1'h0, 8'h00, b, lo);
        check("status4", 32'h195, {23'h0, lo, b});
        $display("test bus4 done");
    endtask : t_bus4

    task automatic t_serial();
        @(posedge i_clk);
        strap_bus <= 1'h0;
        strap_iset <= 1'h0;
        repeat (6) @(posedge i_clk);
        apb(1'h0, LHP_OFF_STATUS, 32'h0, r, e);
        check("modes", 32'h0, r & 32'h3);
        lhp_host_model_i.ser_frame(1'h0, 1'h0, 1'h1, 8'hC3, b);
        lhp_host_model_i.ser_frame(1'h1, 1'h0, 1'h1, 8'h11, b);
        apb(1'h0, LHP_OFF_WDATA, 32'h0, r, e);
        check("ser wdata", 32'hC3, r);
        lhp_host_model_i.ser_frame(1'h0, 1'h1, 1'h0, 8'h00, b);
        check("ser status", 32'h95, {24'h0, b});
        lhp_host_model_i.ser_frame(1'h0, 1'h1, 1'h1, 8'h00, b);
        check("ser data", 32'h3C, {24'h0, b});
        $display("test serial done");
    endtask : t_serial

    initial begin
        repeat (12) @(posedge i_clk);
        i_nrst <= 1'h1;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_bus8();
        t_bus4();
        t_serial();
        close_out();
    end
endmodule : lhp_host_port_tb_top
